// file: rtl/channel_fault_diagnostics.sv
// Purpose: Per-channel protection fault and open-load flags with clear logic
// Assumes: Detector inputs are asynchronous levels; ch_on_req is on mclk
// Notes: Frame events arrive on link_clk and cross via frame_xfer
`timescale 1ns/1ps
`default_nettype none
module channel_fault_diagnostics
	import diag_pkg::*;
#(
	parameter cnt_t OL_DELAY_CYC = cnt_t'(OL_DELAY_CYC_DEF)
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Analog detector levels
	input wire diag_pkg::chan_t ot_det,
	input wire diag_pkg::chan_t ovl_det,
	input wire diag_pkg::chan_t ol_det,
	// Channel request from input selection
	input wire diag_pkg::chan_t ch_on_req,
	// Link side frame events
	input wire logic link_clk,
	input wire logic link_rst,
	input wire logic link_frame_end,
	input wire logic link_wr,
	input wire logic register_bank_select,
	input wire diag_pkg::addr_t link_addr,
	input wire diag_pkg::nib_t link_wdata,
	// Channel control
	output logic [NCH-1:0] ch_enable,
	output logic [NCH-1:0] diag_current_enable,
	// Flags
	output logic [NCH-1:0] protect_fault_flag,
	output logic [NCH-1:0] open_load_flag,
	// Command bits
	output logic clear_protection_bit,
	output logic reset_request,
	output logic standby_request,
	output logic wake_request
);
	import diag_pkg::*;

	typedef struct packed {
		chan_t s1_ot;
		chan_t s1_ovl;
		chan_t s1_ol;
		chan_t s2_ot;
		chan_t s2_ovl;
		chan_t s2_ol;
		chan_t pf;
		chan_t ol;
		chan_t en;
		chan_t dcen;
		logic clr_cmd;
		logic rst_req;
		logic sby;
		logic wake;
		logic [NCH-1:0][CNT_W-1:0] cnt;
	} st_t;

	st_t st_r, st_nxt;
	diag_if fx();

	logic cmd_wr;
	logic clr_pf;
	logic dr_read;
	chan_t ol_clr;
	chan_t ol_set;

	// =====================================
	// Decode helpers
	function automatic logic is_write(input logic ev, input logic wr, input addr_t a, input addr_t code);
		return ev && wr && (a == code);
	endfunction

	function automatic chan_t pair_mask(input logic [1:0] code);
		chan_t m;
		m = '0;
		m[{code, 1'b0}] = 1'b1;
		m[{code, 1'b1}] = 1'b1;
		return m;
	endfunction

	// =====================================
	// Frame crossing
	frame_xfer u_xfer (
		.mclk(mclk),
		.rst(rst),
		.fx(fx),
		.link_clk(link_clk),
		.link_rst(link_rst),
		.link_frame_end(link_frame_end),
		.link_wr(link_wr),
		.register_bank_select(register_bank_select),
		.link_addr(link_addr),
		.link_wdata(link_wdata)
	);

	// =====================================
	// Frame decode
	assign cmd_wr = is_write(fx.ev, fx.wr, fx.addr, ADDR_CMD);
	assign clr_pf = cmd_wr && fx.data[CMD_CLR_BIT];
	// Bank 1, codes 00..11 address the four pair registers
	assign dr_read = fx.ev && !fx.wr && (fx.bank == DIAG_BANK) && !fx.addr[2];
	assign ol_clr = dr_read ? pair_mask(fx.addr[1:0]) : '0;

	// =====================================
	// Next state
	always_comb begin
		st_nxt = st_r;
		ol_set = '0;
		st_nxt.s1_ot = ot_det;
		st_nxt.s1_ovl = ovl_det;
		st_nxt.s1_ol = ol_det;
		st_nxt.s2_ot = st_r.s1_ot;
		st_nxt.s2_ovl = st_r.s1_ovl;
		st_nxt.s2_ol = st_r.s1_ol;

		// Any valid frame drops the bit unless it writes it again
		if (fx.ev) begin
			st_nxt.clr_cmd = clr_pf;
		end
		if (cmd_wr) begin
			st_nxt.rst_req = fx.data[CMD_RST_BIT];
			st_nxt.sby = fx.data[CMD_SBY_BIT];
			st_nxt.wake = fx.data[CMD_WAKE_BIT];
		end
		if (is_write(fx.ev, fx.wr, fx.addr, ADDR_CUR_LO)) begin
			st_nxt.dcen[3:0] = fx.data;
		end else if (is_write(fx.ev, fx.wr, fx.addr, ADDR_CUR_HI)) begin
			st_nxt.dcen[7:4] = fx.data;
		end

		// A live fault beats the clear in the same cycle
		st_nxt.pf = (clr_pf ? FLAG_RST : st_r.pf) | st_r.s2_ot | st_r.s2_ovl;

		// Qualification counter runs only for an off channel seeing open load
		// It saturates, so a flag read away while the load stays open is not set again
		for (int i = 0; i < NCH; i++) begin
			if (st_r.en[i] || !st_r.s2_ol[i]) begin
				st_nxt.cnt[i] = '0;
			end else if (st_r.cnt[i] != OL_DELAY_CYC) begin
				st_nxt.cnt[i] = st_r.cnt[i] + CNT_ONE;
			end
			ol_set[i] = !st_r.en[i] && st_r.s2_ol[i] && (st_r.cnt[i] == OL_DELAY_CYC - CNT_ONE);
		end
		st_nxt.ol = (st_r.ol & ~ol_clr) | ol_set;

		// Latched fault holds the channel off until cleared
		st_nxt.en = ch_on_req & ~st_nxt.pf;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_r <= '0;
			st_r.pf <= FLAG_RST;
			st_r.ol <= FLAG_RST;
			st_r.dcen <= DCEN_RST;
			st_r.clr_cmd <= CMD_BIT_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// =====================================
	// Outputs
	assign ch_enable = st_r.en;
	assign diag_current_enable = st_r.dcen;
	assign protect_fault_flag = st_r.pf;
	assign open_load_flag = st_r.ol;
	assign clear_protection_bit = st_r.clr_cmd;
	assign reset_request = st_r.rst_req;
	assign standby_request = st_r.sby;
	assign wake_request = st_r.wake;

	// =====================================
	// Checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	AST_CLR_SELF: assert property (st_r.clr_cmd && fx.ev && !clr_pf |=> !clear_protection_bit)
		else $error("clear bit did not drop on next frame");

	AST_CLR_WR: assert property (cmd_wr |=> clear_protection_bit == $past(fx.data[CMD_CLR_BIT]))
		else $error("clear bit not taken from command write");

	AST_DCEN_LO: assert property (is_write(fx.ev, fx.wr, fx.addr, ADDR_CUR_LO)
		|=> diag_current_enable[3:0] == $past(fx.data))
		else $error("lower current enables not written");

	AST_DCEN_WR: assert property (is_write(fx.ev, fx.wr, fx.addr, ADDR_CUR_HI)
		|=> diag_current_enable[7:4] == $past(fx.data))
		else $error("upper current enables not written");

	AST_CMD_WR: assert property (cmd_wr |=> standby_request == $past(fx.data[CMD_SBY_BIT]))
		else $error("standby bit not taken from command write");

	// Internal decode is watched so set-versus-clear races stay visible
	for (genvar g = 0; g < NCH; g++) begin : g_chk
		AST_PF_STICKY: assert property (protect_fault_flag[g] && !clr_pf |=> protect_fault_flag[g])
			else $error("fault flag dropped without clear");
		AST_PF_CLR: assert property (clr_pf && !st_r.s2_ot[g] && !st_r.s2_ovl[g]
			|=> !protect_fault_flag[g])
			else $error("fault flag survived a clear with no live fault");
		AST_OL_RDCLR: assert property (ol_clr[g] && !ol_set[g] |=> !open_load_flag[g])
			else $error("open-load flag survived its read");
		AST_OL_HOLD: assert property (open_load_flag[g] && !ol_clr[g] |=> open_load_flag[g])
			else $error("open-load flag dropped without its read");
		AST_OL_ON: assert property (ch_enable[g] && !open_load_flag[g] |=> !open_load_flag[g])
			else $error("open-load flag set while channel on");
		AST_OL_DELAY: assert property ($rose(open_load_flag[g])
			|-> $past(st_r.cnt[g]) == OL_DELAY_CYC - CNT_ONE)
			else $error("open-load flag set before qualification");
		AST_OL_SET: assert property (ol_set[g] |=> open_load_flag[g])
			else $error("qualified open load did not set its flag");
		AST_OT_OFF: assert property (st_r.s2_ot[g] |=> protect_fault_flag[g] && !ch_enable[g])
			else $error("over-temperature did not latch and switch off");
		// A clear right after the fault may legally re-enable a channel whose load recovered
		AST_OVL_OFF: assert property (st_r.s2_ovl[g]
			|=> !ch_enable[g] ##1 (!ch_enable[g] || $past(clr_pf)))
			else $error("over-load did not switch channel off");
		AST_CLR_REFAULT: assert property (clr_pf && st_r.s2_ot[g] |=> protect_fault_flag[g])
			else $error("live fault lost at clear");
	end

endmodule
`default_nettype wire

// file: rtl/diag_if.sv
// Purpose: Carries one decoded frame from the link crossing into the flag logic
// Assumes: ev is a one-cycle mclk pulse with the payload valid alongside
// Notes: Payload holds until the next ev
`timescale 1ns/1ps
`default_nettype none
interface diag_if;
	logic ev;
	logic wr;
	logic bank;
	logic [2:0] addr;
	logic [3:0] data;
	modport src (output ev, output wr, output bank, output addr, output data);
	modport dst (input ev, input wr, input bank, input addr, input data);
endinterface
`default_nettype wire

// file: rtl/diag_pkg.sv
// Purpose: Shared constants and types for the channel fault diagnostics block
// Assumes: 8 channels, 250 MHz mclk, frame events decoded by the SPI front end
// Notes: Overview of operation
// Overview of operation
// - Protection event latches the channel fault flag until a clear-protection command.
// - Clear-protection bit returns to zero on the next valid frame.
// - Open-load events latch per channel; reading its diagnosis register clears it.
// - No open-load diagnosis while a channel is switched on.
// - Off channel showing open load sets its flag after 100 to 250 us.
// - Per-channel diagnosis-current enable: 1 enables, 0 disables the source.
// - Over-temperature sets the fault flag and switches an active channel off.
// - Over-load switches the channel off within 60 us and sets its flag.
// - Four read-only diagnosis registers in bank 1, codes 00 to 11, pair layout.
// - Flag 0 means normal; 1 means the fault occurred.
// - Command register at code 110: clear, reset, standby, wake in bits 0..3.
// - Two current configuration registers hold channels 0-3 and 4-7, second at 101.
package diag_pkg;

	localparam int NCH = 8;
	localparam int CNT_W = 16;

	typedef logic [NCH-1:0] chan_t;
	typedef logic [3:0] nib_t;
	typedef logic [2:0] addr_t;
	typedef logic [CNT_W-1:0] cnt_t;

	// =====================================
	// Register codes and field positions
	localparam addr_t ADDR_CUR_LO = 3'h4;
	localparam addr_t ADDR_CUR_HI = 3'h5;
	localparam addr_t ADDR_CMD = 3'h6;
	localparam int CMD_CLR_BIT = 0;
	localparam int CMD_RST_BIT = 1;
	localparam int CMD_SBY_BIT = 2;
	localparam int CMD_WAKE_BIT = 3;
	localparam int DR_PF_LO = 0;
	localparam int DR_OL_LO = 1;
	localparam int DR_PF_HI = 2;
	localparam int DR_OL_HI = 3;
	localparam logic DIAG_BANK = 1'b1;

	// =====================================
	// Values after reset
	localparam chan_t FLAG_RST = 8'h00;
	localparam chan_t DCEN_RST = 8'h00;
	localparam logic CMD_BIT_RST = 1'b0;
	localparam cnt_t CNT_ONE = 16'h0001;

	// =====================================
	// Timing
	localparam int MCLK_MHZ = 250;
	localparam int OL_DELAY_MIN_US = 100;
	localparam int OL_DELAY_MAX_US = 250;
	localparam int OL_DELAY_CYC_DEF = OL_DELAY_MIN_US * MCLK_MHZ;
	localparam int OVL_OFF_MAX_US = 60;
	localparam int OVL_OFF_MAX_CYC = OVL_OFF_MAX_US * MCLK_MHZ;

endpackage

// file: rtl/frame_xfer.sv
// Purpose: Moves valid-frame events from the link clock into the mclk domain
// Assumes: Frames are far apart compared with a few mclk cycles
// Notes: Toggle handshake; payload is held stable while the toggle crosses
`timescale 1ns/1ps
`default_nettype none
module frame_xfer
	import diag_pkg::*;
(
	// System side
	input wire logic mclk,
	input wire logic rst,
	diag_if.src fx,
	// Link side
	input wire logic link_clk,
	input wire logic link_rst,
	input wire logic link_frame_end,
	input wire logic link_wr,
	input wire logic register_bank_select,
	input wire diag_pkg::addr_t link_addr,
	input wire diag_pkg::nib_t link_wdata
);
	import diag_pkg::*;

	typedef struct packed {
		logic tog;
		logic wr;
		logic bank;
		addr_t addr;
		nib_t data;
	} lnk_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic ev;
		logic wr;
		logic bank;
		addr_t addr;
		nib_t data;
	} sys_t;

	lnk_t lnk_r, lnk_nxt;
	sys_t sys_r, sys_nxt;

	// =====================================
	// Link domain: capture on the frame's own end strobe
	always_comb begin
		lnk_nxt = lnk_r;
		if (link_frame_end) begin
			lnk_nxt.tog = ~lnk_r.tog;
			lnk_nxt.wr = link_wr;
			lnk_nxt.bank = register_bank_select;
			lnk_nxt.addr = link_addr;
			lnk_nxt.data = link_wdata;
		end
	end

	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			lnk_r <= '0;
		end else begin
			lnk_r <= lnk_nxt;
		end
	end

	// =====================================
	// System domain: payload sampled only after the toggle has settled
	always_comb begin
		sys_nxt = sys_r;
		sys_nxt.s1 = lnk_r.tog;
		sys_nxt.s2 = sys_r.s1;
		sys_nxt.s3 = sys_r.s2;
		sys_nxt.ev = sys_r.s2 ^ sys_r.s3;
		if (sys_r.s2 ^ sys_r.s3) begin
			sys_nxt.wr = lnk_r.wr;
			sys_nxt.bank = lnk_r.bank;
			sys_nxt.addr = lnk_r.addr;
			sys_nxt.data = lnk_r.data;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			sys_r <= '0;
		end else begin
			sys_r <= sys_nxt;
		end
	end

	assign fx.ev = sys_r.ev;
	assign fx.wr = sys_r.wr;
	assign fx.bank = sys_r.bank;
	assign fx.addr = sys_r.addr;
	assign fx.data = sys_r.data;

endmodule
`default_nettype wire

// file: sim/link_master.sv
// Purpose: Host side model issuing decoded link frames
// Assumes: Link clock runs only during frames and resets
// Notes: Payload is inverted once released so stale values never pass
`timescale 1ns/1ps
`default_nettype none
module link_master (
	// Link outputs
	output logic link_clk,
	output logic link_rst,
	output logic link_frame_end,
	output logic link_wr,
	output logic register_bank_select,
	output diag_pkg::addr_t link_addr,
	output diag_pkg::nib_t link_wdata
);
	import diag_pkg::*;
	initial begin
		link_clk = 1'b0;
		link_rst = 1'b1;
		link_frame_end = 1'b0;
		link_wr = 1'b0;
		register_bank_select = 1'b0;
		link_addr = 3'h0;
		link_wdata = 4'h0;
	end
	task automatic tick();
		#15 link_clk = 1'b1;
		#15 link_clk = 1'b0;
	endtask
	task automatic reset_link();
		link_rst = 1'b1;
		repeat (3) tick();
		link_rst = 1'b0;
		repeat (2) tick();
	endtask
	// Writing 1 to bit 0 of code 110 is how the host clears faults
	task automatic frame(input logic w, input logic b, input addr_t a, input nib_t d);
		#1.7;
		repeat (2) tick();
		link_wr = w;
		register_bank_select = b;
		link_addr = a;
		link_wdata = d;
		link_frame_end = 1'b1;
		tick();
		link_frame_end = 1'b0;
		link_wr = ~w;
		register_bank_select = ~b;
		link_addr = ~a;
		link_wdata = ~d;
		// Spacing keeps the crossing from being overrun
		repeat (4) tick();
	endtask
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// Purpose: Self-checking bench for the channel fault flags
// Assumes: Short open-load delay parameter
// Notes: Link frames come from the host model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import diag_pkg::*;
	localparam int OLD = 20;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	chan_t ot_det = 8'h00, ovl_det = 8'h00, ol_det = 8'h00, ch_on_req = 8'h00;
	logic link_clk, link_rst, link_frame_end, link_wr, register_bank_select;
	addr_t link_addr;
	nib_t link_wdata;
	logic [7:0] ch_enable, diag_current_enable, protect_fault_flag, open_load_flag;
	logic clear_protection_bit, reset_request, standby_request, wake_request;
	logic [3:0] cmd_bits;
	int n_fail = 0;
	int checks_done = 0;
	assign cmd_bits = {wake_request, standby_request, reset_request, clear_protection_bit};
	always #2 mclk = ~mclk;
	link_master m (.link_clk(link_clk), .link_rst(link_rst), .link_frame_end(link_frame_end),
		.link_wr(link_wr), .register_bank_select(register_bank_select), .link_addr(link_addr),
		.link_wdata(link_wdata));
	channel_fault_diagnostics #(.OL_DELAY_CYC(cnt_t'(OLD))) DUT (.mclk(mclk), .rst(rst),
		.ot_det(ot_det), .ovl_det(ovl_det), .ol_det(ol_det), .ch_on_req(ch_on_req),
		.link_clk(link_clk), .link_rst(link_rst), .link_frame_end(link_frame_end), .link_wr(link_wr),
		.register_bank_select(register_bank_select), .link_addr(link_addr), .link_wdata(link_wdata),
		.ch_enable(ch_enable), .diag_current_enable(diag_current_enable),
		.protect_fault_flag(protect_fault_flag), .open_load_flag(open_load_flag),
		.clear_protection_bit(clear_protection_bit), .reset_request(reset_request),
		.standby_request(standby_request), .wake_request(wake_request));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// =====================================
	// Watchdog
	initial begin
		#100000;
		n_fail++;
		summarize();
	end
	// =====================================
	// Tests
	initial begin
		fork
			m.reset_link();
			begin
				repeat (8) @(posedge mclk);
				rst <= 1'b0;
				cyc(1);
				check(protect_fault_flag | open_load_flag, 8'h00);
				check({4'h0, cmd_bits}, 8'h00);
			end
		join
		@(posedge mclk) ch_on_req <= 8'hff;
		cyc(4);
		$display("test reset done");
		@(posedge mclk) ovl_det <= 8'h02;
		cyc(3);
		check(protect_fault_flag, 8'h02);
		check(ch_enable, 8'hfd);
		@(posedge mclk) begin
			ovl_det <= 8'h00;
			ot_det <= 8'h40;
		end
		cyc(3);
		check(protect_fault_flag, 8'h42);
		check(ch_enable, 8'hbd);
		$display("test protection done");
		@(posedge mclk) ol_det <= 8'h04;
		cyc(2 * OLD);
		check(open_load_flag, 8'h00);
		@(posedge mclk) ch_on_req <= 8'hfb;
		cyc(OLD / 2);
		check(open_load_flag, 8'h00);
		cyc(OLD);
		check(open_load_flag, 8'h04);
		@(posedge mclk) ol_det <= 8'h00;
		m.frame(1'b0, 1'b0, 3'h1, 4'h0);
		check(open_load_flag, 8'h04);
		m.frame(1'b0, 1'b1, 3'h1, 4'h0);
		check(open_load_flag, 8'h00);
		$display("test open load done");
		m.frame(1'b1, 1'b0, ADDR_CMD, 4'h1);
		check(protect_fault_flag, 8'h40);
		check({4'h0, cmd_bits}, 8'h01);
		check(ch_enable, 8'hbb);
		m.frame(1'b1, 1'b0, ADDR_CUR_LO, 4'ha);
		check({4'h0, cmd_bits}, 8'h00);
		m.frame(1'b1, 1'b0, ADDR_CUR_HI, 4'h5);
		check(diag_current_enable, 8'h5a);
		m.frame(1'b1, 1'b0, ADDR_CMD, 4'he);
		check({4'h0, cmd_bits}, 8'h0e);
		$display("test commands done");
		summarize();
	end
endmodule
`default_nettype wire
